// ==== rtl/aawf_pkg.sv ====
// package: encodings, phases, structs for the add/and datapath
package aawf_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned INSTR_W = 14;

  // opcode field positions
  localparam int unsigned OPC_HI    = 13;
  localparam int unsigned OPC_LO    = 8;
  localparam int unsigned DEST_BIT  = 7;
  localparam int unsigned FADDR_HI  = 6;
  localparam int unsigned LIT_HI    = 7;

  // opcode encodings, bits 13:8
  localparam logic [5:0] ADD_LIT_OPC = 6'h3E;  // 11 111x, low bit ignored
  localparam logic [5:0] ADD_LIT_MSK = 6'h3E;
  localparam logic [5:0] AND_LIT_OPC = 6'h39;  // 11 1001
  localparam logic [5:0] ADD_FIL_OPC = 6'h07;  // 00 0111
  localparam logic [5:0] AND_FIL_OPC = 6'h05;  // 00 0101
  localparam logic [5:0] FULL_MSK    = 6'h3F;

  // destination select values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // nibble width for the digit carry
  localparam int unsigned NIB_W = 4;

  // reset values
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       FLAG_RST = 1'b0;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } aawf_phase_t;

  typedef enum logic [1:0] {
    OP_ADD_LIT = 2'h0,
    OP_AND_LIT = 2'h1,
    OP_ADD_FIL = 2'h2,
    OP_AND_FIL = 2'h3
  } aawf_op_t;

  typedef struct packed {
    logic       c;
    logic       dig_c;
    logic       z;
  } aawf_flags_t;

  // file register access towards the register file
  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       presc_clr;
  } aawf_file_req_t;

  typedef struct packed {
    logic [7:0] latch_data;
    logic [7:0] pin_data;
    logic       is_port;
    logic       is_timer0;
    logic       presc_on_timer0;
  } aawf_file_rsp_t;

endpackage : aawf_pkg

// ==== rtl/aawf_alu.sv ====
// combinational adder and AND unit with carry, digit carry and zero
`timescale 1ns/100ps
module aawf_alu #(
  parameter int unsigned WIDTH = 8
) (
  // operands
  input  wire logic [WIDTH-1:0] acc_val,
  input  wire logic [WIDTH-1:0] opnd,
  input  wire logic             do_and,
  // result
  output logic      [WIDTH-1:0] result,
  output aawf_pkg::aawf_flags_t flags
);

  logic [WIDTH:0]               sum;
  logic [aawf_pkg::NIB_W:0]     nib_sum;

  always_comb begin
    sum     = {1'b0, acc_val} + {1'b0, opnd};
    nib_sum = {1'b0, acc_val[aawf_pkg::NIB_W-1:0]}
            + {1'b0, opnd[aawf_pkg::NIB_W-1:0]};
    result  = do_and ? (acc_val & opnd) : sum[WIDTH-1:0];
    flags.c  = sum[WIDTH];                 // RULE_10
    flags.dig_c = nib_sum[aawf_pkg::NIB_W];   // RULE_10
    flags.z  = (result == '0);             // RULE_10
  end

endmodule : aawf_alu

// ==== rtl/aawf_core.sv ====
// four-phase execution of add/and with literal or file register
// Overview of operation
// RULE_01: literal add: accumulator += literal; all three flags updated.
// RULE_02: literal and: accumulator &= literal; only zero flag updated.
// RULE_03: file add: accumulator plus addressed file register; all flags.
// RULE_04: file and: accumulator and file register; only zero flag updated.
// RULE_05: file ops: destination bit 0 writes accumulator, 1 the register.
// RULE_06: file operations: decode Q1, read Q2, process Q3, write Q4.
// RULE_07: literal ops finish in one cycle, accumulator written in Q4.
// RULE_08: port register reads take the pin levels, not the latch.
// RULE_09: writing timer zero count clears prescaler when assigned to it.
// RULE_10: carry from bit 7, digit carry from bit 3, zero on zero result.
`timescale 1ns/100ps
module aawf_core #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // instruction
  input  wire logic [13:0]              instr,
  input  wire logic                     instr_valid,
  // file register port
  output aawf_pkg::aawf_file_req_t      file_req,
  input  wire aawf_pkg::aawf_file_rsp_t file_rsp,
  // architectural state
  output logic [WIDTH-1:0]              working_accumulator,
  output aawf_pkg::aawf_flags_t         status_flags,
  output aawf_pkg::aawf_phase_t         phase,
  output logic                          instr_done,
  output logic                          instr_known
);

  typedef struct packed {
    aawf_pkg::aawf_phase_t ph;
    logic                  act;
    aawf_pkg::aawf_op_t    op;
    logic                  dest;
    logic [6:0]            addr;
    logic [7:0]            opnd;
    logic [7:0]            res;
    aawf_pkg::aawf_flags_t rflg;
    logic [7:0]            acc;
    aawf_pkg::aawf_flags_t flg;
    aawf_pkg::aawf_file_req_t req;
    logic                  done;
  } aawf_state_t;

  aawf_state_t st_q;
  aawf_state_t st_d;

  logic [7:0]            alu_res;
  aawf_pkg::aawf_flags_t alu_flg;
  logic                  alu_and;
  logic                  dec_ok;
  aawf_pkg::aawf_op_t    dec_op;
  logic [5:0]            opc;

  // opcode decode, captured in Q1 and driving instr_known in every phase
  function automatic logic decode(input logic [5:0] o,
                                  output aawf_pkg::aawf_op_t op);
    op = aawf_pkg::OP_ADD_LIT;
    if ((o & aawf_pkg::ADD_LIT_MSK) == aawf_pkg::ADD_LIT_OPC) begin
      op = aawf_pkg::OP_ADD_LIT;
      return 1'b1;
    end
    if (o == aawf_pkg::AND_LIT_OPC) begin
      op = aawf_pkg::OP_AND_LIT;
      return 1'b1;
    end
    if (o == aawf_pkg::ADD_FIL_OPC) begin
      op = aawf_pkg::OP_ADD_FIL;
      return 1'b1;
    end
    if (o == aawf_pkg::AND_FIL_OPC) begin
      op = aawf_pkg::OP_AND_FIL;
      return 1'b1;
    end
    return 1'b0;
  endfunction : decode

  function automatic logic is_file(input aawf_pkg::aawf_op_t op);
    return op == aawf_pkg::OP_ADD_FIL || op == aawf_pkg::OP_AND_FIL;
  endfunction : is_file

  always_comb begin
    opc    = instr[aawf_pkg::OPC_HI:aawf_pkg::OPC_LO];
    dec_ok = decode(opc, dec_op);
  end

  assign alu_and = (st_q.op == aawf_pkg::OP_AND_LIT) ||
                   (st_q.op == aawf_pkg::OP_AND_FIL);

  aawf_alu #(
    .WIDTH (8)
  ) u_alu (
    .acc_val (st_q.acc),
    .opnd    (st_q.opnd),
    .do_and  (alu_and),
    .result  (alu_res),
    .flags   (alu_flg)
  );

  always_comb begin
    st_d          = st_q;
    st_d.req      = '0;
    st_d.done     = 1'b0;
    unique case (st_q.ph)
      aawf_pkg::PH_Q1: begin  // RULE_06
        st_d.ph  = aawf_pkg::PH_Q2;
        st_d.act = instr_valid && dec_ok;
        st_d.op  = dec_op;
        st_d.dest = instr[aawf_pkg::DEST_BIT];
        st_d.addr = instr[aawf_pkg::FADDR_HI:0];
        st_d.opnd = instr[aawf_pkg::LIT_HI:0];
        if (instr_valid && dec_ok && is_file(dec_op)) begin
          st_d.req.rd_en = 1'b1;
          st_d.req.addr  = instr[aawf_pkg::FADDR_HI:0];
        end
      end
      aawf_pkg::PH_Q2: begin
        st_d.ph = aawf_pkg::PH_Q3;
        // port reads take the pin level
        if (st_q.act && is_file(st_q.op)) begin
          st_d.opnd = file_rsp.is_port ? file_rsp.pin_data  // RULE_08
                                       : file_rsp.latch_data;
        end
      end
      aawf_pkg::PH_Q3: begin
        st_d.ph   = aawf_pkg::PH_Q4;
        st_d.res  = alu_res;   // RULE_01 RULE_02 RULE_03 RULE_04
        st_d.rflg = alu_flg;
      end
      aawf_pkg::PH_Q4: begin
        st_d.ph = aawf_pkg::PH_Q1;
        if (st_q.act) begin
          st_d.done = 1'b1;
          if (is_file(st_q.op) && st_q.dest == aawf_pkg::DEST_FILE) begin
            st_d.req.wr_en = 1'b1;  // RULE_05
            st_d.req.addr  = st_q.addr;
            st_d.req.wdata = st_q.res;
            st_d.req.presc_clr = file_rsp.is_timer0 &&
                                 file_rsp.presc_on_timer0;  // RULE_09
          end else begin
            st_d.acc = st_q.res;  // RULE_05 RULE_07
          end
          st_d.flg.z = st_q.rflg.z;  // RULE_02 RULE_04
          if (!alu_and) begin
            st_d.flg.c  = st_q.rflg.c;   // RULE_01 RULE_03
            st_d.flg.dig_c = st_q.rflg.dig_c;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q      <= '0;
      st_q.ph   <= aawf_pkg::PH_Q1;
      st_q.acc  <= aawf_pkg::ACC_RST;
      st_q.flg  <= '{aawf_pkg::FLAG_RST, aawf_pkg::FLAG_RST,
                     aawf_pkg::FLAG_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign working_accumulator = st_q.acc;
  assign status_flags        = st_q.flg;
  assign phase               = st_q.ph;
  assign file_req            = st_q.req;
  assign instr_done          = st_q.done;
  assign instr_known         = dec_ok;

  // sequence of one instruction cycle through its phases, whether or not an instruction is accepted
  sequence s_four_phase;
    phase == aawf_pkg::PH_Q1 ##1 phase == aawf_pkg::PH_Q2
      ##1 phase == aawf_pkg::PH_Q3 ##1 phase == aawf_pkg::PH_Q4;
  endsequence

  a_phase_rotation: assert property (  // RULE_06
    @(posedge clk_sys) disable iff (reset)
    phase == aawf_pkg::PH_Q1 |-> s_four_phase ##1 phase == aawf_pkg::PH_Q1)
    else $error("phase rotation broken");

  a_read_in_q2: assert property (  // RULE_06
    @(posedge clk_sys) disable iff (reset)
    file_req.rd_en |-> phase == aawf_pkg::PH_Q2)
    else $error("file read outside Q2");

  a_write_in_q1: assert property (  // RULE_06
    @(posedge clk_sys) disable iff (reset)
    (file_req.wr_en || instr_done) |-> phase == aawf_pkg::PH_Q1)
    else $error("write not at end of Q4");

  a_add_lit_acc: assert property (  // RULE_01
    @(posedge clk_sys) disable iff (reset)
    (phase == aawf_pkg::PH_Q1 && instr_valid &&
     (instr[13:8] & aawf_pkg::ADD_LIT_MSK) == aawf_pkg::ADD_LIT_OPC)
    |-> ##4 working_accumulator ==
        8'($past(working_accumulator, 4) + $past(instr[7:0], 4)))
    else $error("literal add result wrong");

  a_and_lit_carry: assert property (  // RULE_02
    @(posedge clk_sys) disable iff (reset)
    (phase == aawf_pkg::PH_Q1 && instr_valid &&
     instr[13:8] == aawf_pkg::AND_LIT_OPC)
    |-> ##4 status_flags.c == $past(status_flags.c, 4) &&
        working_accumulator ==
        ($past(working_accumulator, 4) & $past(instr[7:0], 4)))
    else $error("literal and wrong or carry touched");

  a_file_dest_w: assert property (  // RULE_05
    @(posedge clk_sys) disable iff (reset)
    (phase == aawf_pkg::PH_Q1 && instr_valid && instr[7] &&
     (instr[13:8] == aawf_pkg::ADD_FIL_OPC ||
      instr[13:8] == aawf_pkg::AND_FIL_OPC))
    |-> ##4 file_req.wr_en && $stable(working_accumulator))
    else $error("file destination not honoured");

  a_zero_flag: assert property (  // RULE_10
    @(posedge clk_sys) disable iff (reset)
    instr_done && !file_req.wr_en |-> status_flags.z ==
      (working_accumulator == 8'h00))
    else $error("zero flag mismatch");

  a_port_pins: assert property (  // RULE_08
    @(posedge clk_sys) disable iff (reset)
    (phase == aawf_pkg::PH_Q2 && st_q.act && is_file(st_q.op) &&
     file_rsp.is_port) |=> st_q.opnd == $past(file_rsp.pin_data))
    else $error("port operand not from pins");

  a_presc_clear: assert property (  // RULE_09
    @(posedge clk_sys) disable iff (reset)
    (file_req.presc_clr || file_req.wr_en) |->
      file_req.wr_en && file_req.presc_clr ==
      ($past(file_rsp.is_timer0) && $past(file_rsp.presc_on_timer0)))
    else $error("prescaler clear wrong");

endmodule : aawf_core

// ==== verification/tb.sv ====
// self-checking bench for the add/and execution datapath
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [7:0] acc;
    logic [2:0] flg;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       presc;
  } aawf_note_t;

  logic                     clk_sys;
  logic                     reset;
  logic [13:0]              instr;
  logic                     instr_valid;
  aawf_pkg::aawf_file_req_t file_req;
  aawf_pkg::aawf_file_rsp_t file_rsp;
  logic [7:0]               working_accumulator;
  aawf_pkg::aawf_flags_t    status_flags;
  aawf_pkg::aawf_phase_t    phase;
  logic                     instr_done;
  logic                     instr_known;
  int                       num_errors;
  int                       checks_done;
  int                       seed;
  aawf_note_t               notes[$];
  logic [7:0]               m_acc;
  logic [2:0]               m_flg;
  logic                     cur_file;
  logic [6:0]               cur_addr;

  aawf_core #(.WIDTH(8)) DUT (
    .clk_sys             (clk_sys),
    .reset               (reset),
    .instr               (instr),
    .instr_valid         (instr_valid),
    .file_req            (file_req),
    .file_rsp            (file_rsp),
    .working_accumulator (working_accumulator),
    .status_flags        (status_flags),
    .phase               (phase),
    .instr_done          (instr_done),
    .instr_known         (instr_known)
  );

  always #4 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // one instruction cycle; expectation noted only if it will execute
  task automatic exec(input logic [5:0] opc, input logic [7:0] low,
                      input logic vld, input aawf_pkg::aawf_file_rsp_t r);
    logic       kn;
    logic       fil;
    logic       isand;
    logic [7:0] opnd;
    logic [8:0] sum;
    logic [4:0] nib;
    aawf_note_t n;
    while (phase !== aawf_pkg::PH_Q1) begin
      @(posedge clk_sys);
      #1;
    end
    instr = {opc, low};
    instr_valid = vld;
    file_rsp = r;
    fil = (opc == 6'h07) || (opc == 6'h05);
    isand = (opc == 6'h39) || (opc == 6'h05);
    kn = fil || isand || (opc[5:1] == 5'h1F);
    opnd = !fil ? low : (r.is_port ? r.pin_data : r.latch_data);
    sum = {1'b0, m_acc} + {1'b0, opnd};
    nib = {1'b0, m_acc[3:0]} + {1'b0, opnd[3:0]};
    n.wdata = isand ? (m_acc & opnd) : sum[7:0];
    n.wr = fil && low[7];
    n.addr = low[6:0];
    n.presc = n.wr && r.is_timer0 && r.presc_on_timer0;
    #1;
    check("instr_known", instr_known, kn);
    if (vld && kn) begin
      m_flg[0] = (n.wdata == 8'h00);
      if (!isand) begin
        m_flg[2:1] = {sum[8], nib[4]};
      end
      if (!n.wr) begin
        m_acc = n.wdata;
      end
      n.acc = m_acc;
      n.flg = m_flg;
      notes.push_back(n);
    end
    cur_file = vld && kn && fil;
    cur_addr = low[6:0];
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
  endtask : exec

  task automatic set_acc(input logic [7:0] v);
    exec(6'h39, 8'h00, 1'b1, '0);
    exec(6'h3E, v, 1'b1, '0);
  endtask : set_acc

  always @(negedge clk_sys) begin : mon
    aawf_note_t n;
    if (!reset && phase === aawf_pkg::PH_Q2) begin
      check("rd_en", file_req.rd_en, cur_file);
      if (cur_file) check("rd_addr", file_req.addr, cur_addr);
    end
    if (instr_done === 1'b1) begin
      if (notes.size() == 0) begin
        check("spurious_done", 1'b1, 1'b0);
      end else begin
        n = notes.pop_front();
        check("done_phase", phase, aawf_pkg::PH_Q1);
        check("acc", working_accumulator, n.acc);
        check("flags", status_flags, n.flg);
        check("wr_en", file_req.wr_en, n.wr);
        check("presc_clr", file_req.presc_clr, n.presc);
        if (n.wr) begin
          check("wdata", file_req.wdata, n.wdata);
          check("wr_addr", file_req.addr, n.addr);
        end
      end
    end
  end

  initial begin
    aawf_pkg::aawf_file_rsp_t r;
    logic [5:0]               ops[6];
    ops = '{6'h3E, 6'h3F, 6'h39, 6'h07, 6'h05, 6'h3A};
    clk_sys = 1'b0;
    reset = 1'b1;
    instr = '0;
    instr_valid = 1'b0;
    file_rsp = '0;
    num_errors = 0;
    checks_done = 0;
    seed = 90917;
    m_acc = 8'h00;
    m_flg = 3'h0;
    cur_file = 1'b0;
    cur_addr = '0;
    repeat (12) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    set_acc(8'h10);
    exec(6'h3F, 8'h15, 1'b1, '0);
    set_acc(8'hA3);
    exec(6'h39, 8'h5F, 1'b1, '0);
    set_acc(8'hFF);
    exec(6'h3E, 8'h01, 1'b1, '0);
    r = '0;
    r.latch_data = 8'hC2;
    set_acc(8'h17);
    exec(6'h07, 8'h05, 1'b1, r);
    set_acc(8'h17);
    exec(6'h05, 8'hFF, 1'b1, r);
    // random mix, including refused words and unknown opcodes
    for (int i = 0; i < 80; i++) begin
      r = 19'($random(seed));
      exec(ops[$unsigned($random(seed)) % 6], 8'($random(seed)),
           ($random(seed) & 3) != 0, r);
    end
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    m_acc = 8'h00;
    m_flg = 3'h0;
    cur_file = 1'b0;
    check("reset_acc", working_accumulator, 8'h00);
    check("reset_flags", status_flags, 3'h0);
    exec(6'h3E, 8'h80, 1'b1, '0);
    exec(6'h3E, 8'h80, 1'b1, '0);
    repeat (6) @(posedge clk_sys);
    check("pending", notes.size(), 0);
    end_of_test();
  end

  // whole run is a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end
endmodule : tb
